// ==== src/axis_input_pkg.sv ====
// Constants shared by the per-axis feedback and manual input stage.
// Assumes a 32-bit AXI4-Lite register slave with an 8-bit byte address.
package axis_input_pkg;

  // Register byte offsets.
  localparam logic [7:0] CTRL_OFF = 8'h00;
  localparam logic [7:0] FEED_LEN_OFF = 8'h04;
  localparam logic [7:0] COUNT_BASE_OFF = 8'h08;
  localparam logic [7:0] EXT_STATUS_OFF = 8'h18;

  // Control register field positions.
  localparam int ENC_MODE_LSB = 0;
  localparam int ENC_REV_BIT = 2;
  localparam int HW_MODE_LSB = 4;
  localparam int HW_REV_BIT = 6;
  localparam int JOG_MODE_LSB = 8;
  localparam int USE_MARKER_BIT = 10;
  localparam int CLEAR_SEL_LSB = 12;
  localparam int POL_LSB = 16;

  // Values after reset: 4x decoding on both inputs, every input active low.
  localparam logic [31:0] CTRL_RESET = 32'h0000_0022;
  localparam logic [31:0] FEED_LEN_RESET = 32'h0000_0000;

  // Polarity bit index inside the polarity field.
  localparam int POL_MARKER = 0;
  localparam int POL_JOG = 1;
  localparam int POL_OVR = 2;
  localparam int POL_INPOS = 3;
  localparam int POL_CLR = 4;

  // Pin index inside the synchronised pin vector.
  localparam int PIN_QA = 0;
  localparam int PIN_QB = 1;
  localparam int PIN_MARKER = 2;
  localparam int PIN_HWA = 3;
  localparam int PIN_HWB = 4;
  localparam int PIN_HWEN_N = 5;
  localparam int PIN_JOGP = 6;
  localparam int PIN_JOGM = 7;
  localparam int PIN_OVR = 8;
  localparam int PIN_INPOS = 9;
  localparam int PIN_CLR = 10;
  localparam int NUM_PINS = 11;

  localparam int NUM_COUNTERS = 4;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    DEC_X1 = 2'b00,
    DEC_X2 = 2'b01,
    DEC_X4 = 2'b10,
    DEC_UPDOWN = 2'b11
  } dec_mode_e;

  typedef enum logic [1:0] {
    JOG_FEED_LEN = 2'b00,
    JOG_CONST = 2'b01,
    JOG_HIGH = 2'b10,
    JOG_SPARE = 2'b11
  } jog_mode_e;

endpackage

// ==== src/axis_inputs.sv ====
// Per-axis feedback and manual input stage with an AXI4-Lite register slave.
// Assumes pins are asynchronous to CORE_CLK and the motion core consumes
// the one-cycle request pulses given here on the same clock.
`timescale 1ns/100ps

// Notes on behaviour
// - Encoder input decodes quadrature at 1x, 2x or 4x, or up/down pulses.
// - Encoder counts up when A leads B, down when B leads A.
// - Separate software bits reverse the count direction of encoder and handwheel.
// - During origin return with marker use, the marker refines home position.
// - Handwheel input decodes quadrature at 1x, 2x or 4x, or up/down pulses.
// - Handwheel counts up when A leads B, down when B leads A.
// - Handwheel and jog inputs count only while the enable pin is low.
// - An asserted jog switch starts motion in its own direction.
// - Jog motion is a fixed feed length, constant or high-speed feed.
// - The override trigger starts the second target-position override.
// - The clear input resets every software-selected position counter.
// - Inputs have selectable polarity and their levels read as extension status.
module axis_inputs (
  input wire logic CORE_CLK,
  input wire logic SRST,
  input wire logic QUAD_A_FEEDBACK,
  input wire logic QUAD_B_FEEDBACK,
  input wire logic INDEX_MARKER_IN,
  input wire logic HANDWHEEL_A_IN,
  input wire logic HANDWHEEL_B_IN,
  input wire logic HANDWHEEL_ENABLE_N,
  input wire logic JOG_PLUS_IN,
  input wire logic JOG_MINUS_IN,
  input wire logic TARGET_OVERRIDE_TRIGGER,
  input wire logic SERVO_IN_POSITION,
  input wire logic COUNTER_CLEAR_IN,
  input wire logic ORIGIN_RETURN_ACTIVE,
  output logic HOME_MARKER,
  output logic HW_STEP,
  output logic HW_UP,
  output logic JOG_START,
  output logic JOG_DIR_PLUS,
  output logic [1:0] JOG_FEED_MODE,
  output logic JOG_RELEASE,
  output logic [31:0] JOG_FEED_LENGTH,
  output logic OVERRIDE2_START,
  output logic IN_POSITION,
  input wire logic [7:0] S_AXI_AWADDR,
  input wire logic S_AXI_AWVALID,
  output logic S_AXI_AWREADY,
  input wire logic [31:0] S_AXI_WDATA,
  input wire logic [3:0] S_AXI_WSTRB,
  input wire logic S_AXI_WVALID,
  output logic S_AXI_WREADY,
  output logic [1:0] S_AXI_BRESP,
  output logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  input wire logic [7:0] S_AXI_ARADDR,
  input wire logic S_AXI_ARVALID,
  output logic S_AXI_ARREADY,
  output logic [31:0] S_AXI_RDATA,
  output logic [1:0] S_AXI_RRESP,
  output logic S_AXI_RVALID,
  input wire logic S_AXI_RREADY
);
  import axis_input_pkg::*;

  logic [NUM_PINS-1:0] pins;
  logic [NUM_PINS-1:0] sync1;
  logic [NUM_PINS-1:0] sync2;
  logic [31:0] ctrl;
  logic [4:0] pol;
  logic [4:0] act;
  logic [4:0] act_q;
  logic [4:0] rise;
  logic hw_enabled;
  logic enc_step;
  logic enc_up;
  logic hw_step_raw;
  logic hw_up_raw;
  logic jog_p;
  logic jog_m;
  logic jog_p_q;
  logic jog_m_q;
  logic jog_run;
  logic [NUM_COUNTERS-1:0] cnt_inc;
  logic [NUM_COUNTERS-1:0] cnt_dec;
  logic [NUM_COUNTERS-1:0] cnt_clr;
  logic [31:0] count [NUM_COUNTERS];
  logic wr_go;
  logic rd_go;
  logic [31:0] next_rdata;
  logic [1:0] next_rresp;
  logic [1:0] next_bresp;

  assign pins = {COUNTER_CLEAR_IN, SERVO_IN_POSITION, TARGET_OVERRIDE_TRIGGER,
                 JOG_MINUS_IN, JOG_PLUS_IN, HANDWHEEL_ENABLE_N, HANDWHEEL_B_IN,
                 HANDWHEEL_A_IN, INDEX_MARKER_IN, QUAD_B_FEEDBACK, QUAD_A_FEEDBACK};

  // Two-stage synchroniser per pin; only sync2 is read by the logic.
  genvar gi;
  generate
    for (gi = 0; gi < NUM_PINS; gi++) begin : g_sync
      always_ff @(posedge CORE_CLK) begin
        if (SRST) begin
          sync1[gi] <= 1'b0;
          sync2[gi] <= 1'b0;
        end else begin
          sync1[gi] <= pins[gi];
          sync2[gi] <= sync1[gi];
        end
      end
    end
  endgenerate

  // A clear polarity bit means the input is active low, as the pins idle high.
  assign pol = ctrl[POL_LSB +: 5];
  assign act[POL_MARKER] = sync2[PIN_MARKER] ^ ~pol[POL_MARKER];
  assign act[POL_JOG] = 1'b0;
  assign act[POL_OVR] = sync2[PIN_OVR] ^ ~pol[POL_OVR];
  assign act[POL_INPOS] = sync2[PIN_INPOS] ^ ~pol[POL_INPOS];
  assign act[POL_CLR] = sync2[PIN_CLR] ^ ~pol[POL_CLR];
  assign jog_p = sync2[PIN_JOGP] ^ ~pol[POL_JOG];
  assign jog_m = sync2[PIN_JOGM] ^ ~pol[POL_JOG];
  assign hw_enabled = ~sync2[PIN_HWEN_N];
  assign rise = act & ~act_q;

  // Edge history of the conditioned inputs. It starts high, the level that an
  // active-low input shows while the synchronisers are cleared, so that leaving
  // reset is never mistaken for an override, marker, clear or jog edge.
  always_ff @(posedge CORE_CLK) begin
    if (SRST) begin
      act_q <= 5'h1F;
      jog_p_q <= 1'b1;
      jog_m_q <= 1'b1;
    end else begin
      act_q <= act;
      jog_p_q <= jog_p;
      jog_m_q <= jog_m;
    end
  end

  quad_decoder u_enc_dec (
    .clk(CORE_CLK),
    .srst(SRST),
    .a(sync2[PIN_QA]),
    .b(sync2[PIN_QB]),
    .mode(dec_mode_e'(ctrl[ENC_MODE_LSB +: 2])),
    .reverse(ctrl[ENC_REV_BIT]),
    .step(enc_step),
    .up(enc_up)
  );

  quad_decoder u_hw_dec (
    .clk(CORE_CLK),
    .srst(SRST),
    .a(sync2[PIN_HWA]),
    .b(sync2[PIN_HWB]),
    .mode(dec_mode_e'(ctrl[HW_MODE_LSB +: 2])),
    .reverse(ctrl[HW_REV_BIT]),
    .step(hw_step_raw),
    .up(hw_up_raw)
  );

  // Handwheel drive pulses, marker, override and in-position to the motion core.
  always_ff @(posedge CORE_CLK) begin
    if (SRST) begin
      HW_STEP <= 1'b0;
      HW_UP <= 1'b1;
      HOME_MARKER <= 1'b0;
      OVERRIDE2_START <= 1'b0;
      IN_POSITION <= 1'b0;
    end else begin
      HW_STEP <= hw_step_raw & hw_enabled;
      HW_UP <= hw_up_raw;
      HOME_MARKER <= rise[POL_MARKER] & ORIGIN_RETURN_ACTIVE & ctrl[USE_MARKER_BIT];
      OVERRIDE2_START <= rise[POL_OVR];
      IN_POSITION <= act[POL_INPOS];
    end
  end

  // Jog switches: a press starts motion; in the continuous modes the release,
  // or losing the enable, tells the motion core to decelerate and stop.
  // Both switches pressed in one cycle start nothing, since the way is unclear.
  always_ff @(posedge CORE_CLK) begin
    if (SRST) begin
      JOG_START <= 1'b0;
      JOG_DIR_PLUS <= 1'b1;
      JOG_FEED_MODE <= JOG_FEED_LEN;
      JOG_RELEASE <= 1'b0;
      jog_run <= 1'b0;
    end else begin
      JOG_START <= 1'b0;
      JOG_RELEASE <= 1'b0;
      if (jog_run) begin
        if (!hw_enabled || (JOG_DIR_PLUS ? !jog_p : !jog_m)) begin
          JOG_RELEASE <= 1'b1;
          jog_run <= 1'b0;
        end
      end else if (hw_enabled && ((jog_p && !jog_p_q) ^ (jog_m && !jog_m_q))) begin
        JOG_START <= 1'b1;
        JOG_DIR_PLUS <= jog_p && !jog_p_q;
        JOG_FEED_MODE <= ctrl[JOG_MODE_LSB +: 2];
        jog_run <= ctrl[JOG_MODE_LSB +: 2] != JOG_FEED_LEN;
      end
    end
  end

  // Counter sources: encoder, gated handwheel, marker edges and jog starts.
  assign cnt_inc = {JOG_START, rise[POL_MARKER], HW_STEP & HW_UP, enc_step & enc_up};
  assign cnt_dec = {1'b0, 1'b0, HW_STEP & ~HW_UP, enc_step & ~enc_up};
  assign cnt_clr = {4{rise[POL_CLR]}} & ctrl[CLEAR_SEL_LSB +: 4];

  // One counter per entry; a clear beats a count landing in the same cycle.
  generate
    for (gi = 0; gi < NUM_COUNTERS; gi++) begin : g_cnt
      always_ff @(posedge CORE_CLK) begin
        if (SRST || cnt_clr[gi]) begin
          count[gi] <= 32'h0000_0000;
        end else if (cnt_inc[gi]) begin
          count[gi] <= count[gi] + 32'h0000_0001;
        end else if (cnt_dec[gi]) begin
          count[gi] <= count[gi] - 32'h0000_0001;
        end
      end
    end
  endgenerate

  // Address and data are taken together, so neither can be orphaned.
  assign wr_go = S_AXI_AWVALID && S_AXI_WVALID && !S_AXI_AWREADY && !S_AXI_BVALID;
  assign rd_go = S_AXI_ARVALID && !S_AXI_ARREADY && !S_AXI_RVALID;
  assign next_bresp = (S_AXI_AWADDR == CTRL_OFF || S_AXI_AWADDR == FEED_LEN_OFF
                       || (S_AXI_AWADDR >= COUNT_BASE_OFF && S_AXI_AWADDR <= EXT_STATUS_OFF
                           && S_AXI_AWADDR[1:0] == 2'h0)) ? RESP_OKAY : RESP_SLVERR;

  // Write channel handshake and response.
  always_ff @(posedge CORE_CLK) begin
    if (SRST) begin
      S_AXI_AWREADY <= 1'b0;
      S_AXI_WREADY <= 1'b0;
      S_AXI_BVALID <= 1'b0;
      S_AXI_BRESP <= RESP_OKAY;
    end else begin
      S_AXI_AWREADY <= wr_go;
      S_AXI_WREADY <= wr_go;
      if (S_AXI_AWREADY) begin
        S_AXI_BVALID <= 1'b1;
        S_AXI_BRESP <= next_bresp;
      end else if (S_AXI_BREADY) begin
        S_AXI_BVALID <= 1'b0;
      end
    end
  end

  // Writable registers; byte strobes select the lanes that change.
  always_ff @(posedge CORE_CLK) begin
    if (SRST) begin
      ctrl <= CTRL_RESET;
      JOG_FEED_LENGTH <= FEED_LEN_RESET;
    end else if (S_AXI_AWREADY) begin
      for (int i = 0; i < 4; i++) begin
        if (S_AXI_WSTRB[i] && S_AXI_AWADDR == CTRL_OFF) begin
          ctrl[8*i +: 8] <= S_AXI_WDATA[8*i +: 8];
        end
        if (S_AXI_WSTRB[i] && S_AXI_AWADDR == FEED_LEN_OFF) begin
          JOG_FEED_LENGTH[8*i +: 8] <= S_AXI_WDATA[8*i +: 8];
        end
      end
    end
  end

  // Read mux; the extension status word shows raw synchronised pin levels, with jog_run in bit 7.
  always_comb begin
    next_rdata = 32'h0000_0000;
    next_rresp = RESP_OKAY;
    unique case (S_AXI_ARADDR)
      CTRL_OFF: next_rdata = ctrl;
      FEED_LEN_OFF: next_rdata = JOG_FEED_LENGTH;
      COUNT_BASE_OFF: next_rdata = count[0];
      COUNT_BASE_OFF + 8'h04: next_rdata = count[1];
      COUNT_BASE_OFF + 8'h08: next_rdata = count[2];
      COUNT_BASE_OFF + 8'h0C: next_rdata = count[3];
      EXT_STATUS_OFF: next_rdata = {24'h00_0000, jog_run, sync2[PIN_HWEN_N],
                                    sync2[PIN_CLR], sync2[PIN_INPOS], sync2[PIN_OVR],
                                    sync2[PIN_JOGM], sync2[PIN_JOGP],
                                    sync2[PIN_MARKER]};
      default: next_rresp = RESP_SLVERR;
    endcase
  end

  // Read channel; data is captured on the same edge that the address is taken.
  always_ff @(posedge CORE_CLK) begin
    if (SRST) begin
      S_AXI_ARREADY <= 1'b0;
      S_AXI_RVALID <= 1'b0;
      S_AXI_RDATA <= 32'h0000_0000;
      S_AXI_RRESP <= RESP_OKAY;
    end else begin
      S_AXI_ARREADY <= rd_go;
      if (S_AXI_ARREADY) begin
        S_AXI_RVALID <= 1'b1;
        S_AXI_RDATA <= next_rdata;
        S_AXI_RRESP <= next_rresp;
      end else if (S_AXI_RREADY) begin
        S_AXI_RVALID <= 1'b0;
      end
    end
  end

  // Checks on the pin path; an attempt begun at a reset edge is not judged.
  a_sync_delay: assert property (@(posedge CORE_CLK) disable iff (SRST)
    !SRST |-> ##2 (sync2 == $past(pins, 2)))
    else $error("Pin did not arrive after two stages");
  a_hw_gate: assert property (@(posedge CORE_CLK) disable iff (SRST)
    (!hw_enabled && !JOG_START) |=> (!HW_STEP && !JOG_START))
    else $error("Manual input honoured while disabled");
  a_jog_start: assert property (@(posedge CORE_CLK) disable iff (SRST)
    (hw_enabled && !jog_run && jog_p && !jog_p_q && !(jog_m && !jog_m_q))
    |=> (JOG_START && JOG_DIR_PLUS))
    else $error("Plus jog did not start motion");
  a_jog_mode: assert property (@(posedge CORE_CLK) disable iff (SRST)
    JOG_START |-> (JOG_FEED_MODE == $past(ctrl[JOG_MODE_LSB +: 2])
                   && jog_run == (JOG_FEED_MODE != JOG_FEED_LEN)))
    else $error("Jog mode not taken from control");
  a_override_go: assert property (@(posedge CORE_CLK) disable iff (SRST)
    rise[POL_OVR] |=> OVERRIDE2_START ##1 !OVERRIDE2_START)
    else $error("Override trigger not a single pulse");
  a_marker_home: assert property (@(posedge CORE_CLK) disable iff (SRST)
    HOME_MARKER |-> $past(ORIGIN_RETURN_ACTIVE && ctrl[USE_MARKER_BIT]))
    else $error("Marker used outside origin return");
  a_clear_sel: assert property (@(posedge CORE_CLK) disable iff (SRST)
    (rise[POL_CLR] && ctrl[CLEAR_SEL_LSB]) |=> (count[0] == 32'h0000_0000))
    else $error("Selected counter not cleared");
  a_enc_count: assert property (@(posedge CORE_CLK) disable iff (SRST)
    (enc_step && enc_up && !cnt_clr[0]) |=> (count[0] == $past(count[0]) + 32'h0000_0001))
    else $error("Encoder step did not count");
  a_in_position: assert property (@(posedge CORE_CLK) disable iff (SRST)
    !SRST |=> (IN_POSITION == $past(sync2[PIN_INPOS] == pol[POL_INPOS])))
    else $error("In-position level ignores its polarity");

  // Covers for continuous jog, marker, clear, override and handwheel travel.
  c_jog_cont: cover property (@(posedge CORE_CLK) JOG_START && jog_run ##[1:50] JOG_RELEASE);
  c_marker: cover property (@(posedge CORE_CLK) HOME_MARKER);
  c_clear: cover property (@(posedge CORE_CLK) |cnt_clr);
  c_override: cover property (@(posedge CORE_CLK) OVERRIDE2_START);
  c_hw_down: cover property (@(posedge CORE_CLK) HW_STEP && !HW_UP);

endmodule

// ==== src/quad_decoder.sv ====
// Two-phase decoder for one pair of already synchronised pulse inputs.
// Assumes a and b are on the core clock; gives one step pulse per count.
`timescale 1ns/100ps
module quad_decoder (
  input wire logic clk,
  input wire logic srst,
  input wire logic a,
  input wire logic b,
  input wire axis_input_pkg::dec_mode_e mode,
  input wire logic reverse,
  output logic step,
  output logic up
);
  import axis_input_pkg::*;

  logic a_q;
  logic b_q;
  logic a_edge;
  logic b_edge;
  logic next_step;
  logic next_up;

  // Previous levels, used to find the edges.
  always_ff @(posedge clk) begin
    if (srst) begin
      a_q <= 1'b0;
      b_q <= 1'b0;
    end else begin
      a_q <= a;
      b_q <= b;
    end
  end

  assign a_edge = a ^ a_q;
  assign b_edge = b ^ b_q;

  // Both phases moving together is a skipped state; 2x and 4x leave it uncounted, while 1x and up/down can count it.
  always_comb begin
    next_step = 1'b0;
    next_up = 1'b1;
    unique case (mode)
      DEC_X1: begin
        next_step = a & ~a_q;
        next_up = ~b;
      end
      DEC_X2: begin
        next_step = a_edge & ~b_edge;
        next_up = a ^ b;
      end
      DEC_X4: begin
        next_step = a_edge ^ b_edge;
        next_up = a_edge ? (a ^ b) : ~(a ^ b);
      end
      DEC_UPDOWN: begin
        next_step = (a & ~a_q) ^ (b & ~b_q);
        next_up = a & ~a_q;
      end
    endcase
  end

  // Reversal simply swaps the reported direction.
  always_ff @(posedge clk) begin
    if (srst) begin
      step <= 1'b0;
      up <= 1'b1;
    end else begin
      step <= next_step;
      up <= next_up ^ reverse;
    end
  end

  a_quad_lead_up: assert property (@(posedge clk) disable iff (srst)
    (mode == DEC_X4 && !reverse && a && !a_q && !b && !b_q) |=> (step && up))
    else $error("A leading B did not count up");
  a_quad_lead_down: assert property (@(posedge clk) disable iff (srst)
    (mode == DEC_X4 && !reverse && b && !b_q && !a && !a_q) |=> (step && !up))
    else $error("B leading A did not count down");
  a_updown_pulse: assert property (@(posedge clk) disable iff (srst)
    (mode == DEC_UPDOWN && b && !b_q && !(a && !a_q)) |=> (step && (up == reverse)))
    else $error("Pulse on B did not count down");

endmodule

// ==== verification/pulser_model.sv ====
// Behavioural encoder with index marker and a manual handwheel pulser.
// Assumes the bench calls move() just after a rising edge of clk.
`timescale 1ns/100ps
module pulser_model (
  input wire logic clk,
  output logic qa,
  output logic qb,
  output logic mk,
  output logic ha,
  output logic hb
);
  int pos;

  // Lines idle low, marker idle high because its default sense is active low.
  initial begin
    qa = 1'b0;
    qb = 1'b0;
    ha = 1'b0;
    hb = 1'b0;
    mk = 1'b1;
    pos = 0;
  end

  // Each state holds four cycles, so the decoder never sees a phase too short.
  task automatic move(input logic hw, input logic up, input logic ud, input int n);
    logic [7:0] seq;
    int i;
    int j;
    seq = ud ? (up ? 8'hA0 : 8'h50) : (up ? 8'hB4 : 8'h78);
    for (i = 0; i < n; i++) begin
      for (j = 0; j < 4; j++) begin
        if (hw) begin
          {ha, hb} <= seq[7-2*j -: 2];
        end else begin
          {qa, qb} <= seq[7-2*j -: 2];
        end
        repeat (4) @(posedge clk);
      end
      // One marker pulse every second cycle of travel, whichever way it turns.
      if (!hw) begin
        pos += up ? 1 : -1;
        if (pos % 2 == 0) begin
          mk <= 1'b0;
          repeat (4) @(posedge clk);
          mk <= 1'b1;
          repeat (4) @(posedge clk);
        end
      end
    end
  endtask
endmodule

// ==== verification/test_axis_inputs.sv ====
// Self-checking bench for the per-axis feedback and manual input stage.
// Assumes one axis, a pulser model on the pins and AXI4-Lite register access.
`timescale 1ns/100ps
module test_axis_inputs;
  import axis_input_pkg::*;
  typedef struct {
    logic sel;
    dec_mode_e mode;
    logic rev;
    logic up;
    logic en_n;
    logic [31:0] exp;
  } row_s;
  logic CORE_CLK = 1'b0, SRST = 1'b1, MK, JOG_PLUS_IN = 1'b1, JOG_MINUS_IN = 1'b1;
  logic HANDWHEEL_ENABLE_N = 1'b0, TARGET_OVERRIDE_TRIGGER = 1'b1, SERVO_IN_POSITION = 1'b1;
  logic COUNTER_CLEAR_IN = 1'b1, ORIGIN_RETURN_ACTIVE = 1'b0, QA, QB, HA, HB;
  logic HOME_MARKER, HW_STEP, HW_UP, JOG_START, JOG_DIR_PLUS, JOG_RELEASE, OVERRIDE2_START;
  logic IN_POSITION, AWR, WR, BV, ARR, RV;
  logic [1:0] JOG_FEED_MODE, BRESP, RRESP, r;
  logic [31:0] JOG_FEED_LENGTH, RDATA, d, c, b0;
  logic [7:0] AWADDR = 8'h00, ARADDR = 8'h00;
  logic [31:0] WDATA = 32'h0;
  logic AWV = 1'b0, WV = 1'b0, BRDY = 1'b0, ARV = 1'b0, RRDY = 1'b0;
  int bad_count = 0, n_tests = 0, n_start = 0, n_rel = 0, n_home = 0, n_ovr = 0, i, s0, r0;
  row_s rows[10];

  always #12.5 CORE_CLK = ~CORE_CLK;

  pulser_model model (.clk(CORE_CLK), .qa(QA), .qb(QB), .mk(MK), .ha(HA), .hb(HB));

  axis_inputs DUT (.CORE_CLK(CORE_CLK), .SRST(SRST), .QUAD_A_FEEDBACK(QA),
    .QUAD_B_FEEDBACK(QB), .INDEX_MARKER_IN(MK), .HANDWHEEL_A_IN(HA), .HANDWHEEL_B_IN(HB),
    .HANDWHEEL_ENABLE_N(HANDWHEEL_ENABLE_N), .JOG_PLUS_IN(JOG_PLUS_IN),
    .JOG_MINUS_IN(JOG_MINUS_IN), .TARGET_OVERRIDE_TRIGGER(TARGET_OVERRIDE_TRIGGER),
    .SERVO_IN_POSITION(SERVO_IN_POSITION), .COUNTER_CLEAR_IN(COUNTER_CLEAR_IN),
    .ORIGIN_RETURN_ACTIVE(ORIGIN_RETURN_ACTIVE), .HOME_MARKER(HOME_MARKER), .HW_STEP(HW_STEP),
    .HW_UP(HW_UP), .JOG_START(JOG_START), .JOG_DIR_PLUS(JOG_DIR_PLUS),
    .JOG_FEED_MODE(JOG_FEED_MODE), .JOG_RELEASE(JOG_RELEASE),
    .JOG_FEED_LENGTH(JOG_FEED_LENGTH), .OVERRIDE2_START(OVERRIDE2_START),
    .IN_POSITION(IN_POSITION), .S_AXI_AWADDR(AWADDR), .S_AXI_AWVALID(AWV),
    .S_AXI_AWREADY(AWR), .S_AXI_WDATA(WDATA), .S_AXI_WSTRB(4'hF), .S_AXI_WVALID(WV),
    .S_AXI_WREADY(WR), .S_AXI_BRESP(BRESP), .S_AXI_BVALID(BV), .S_AXI_BREADY(BRDY),
    .S_AXI_ARADDR(ARADDR), .S_AXI_ARVALID(ARV), .S_AXI_ARREADY(ARR), .S_AXI_RDATA(RDATA),
    .S_AXI_RRESP(RRESP), .S_AXI_RVALID(RV), .S_AXI_RREADY(RRDY));

  // Pulse counters let tests look at one-cycle outputs without racing them.
  always @(posedge CORE_CLK) begin
    n_start += (JOG_START === 1'b1);
    n_rel += (JOG_RELEASE === 1'b1);
    n_home += (HOME_MARKER === 1'b1);
    n_ovr += (OVERRIDE2_START === 1'b1);
  end

  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      bad_count++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge CORE_CLK);
  endtask

  // Address and data are released each on its own ready; the reply ends the wait.
  task automatic wr(input logic [7:0] a, input logic [31:0] v, output logic [1:0] rs);
    int k;
    @(posedge CORE_CLK);
    AWADDR <= a;
    WDATA <= v;
    AWV <= 1'b1;
    WV <= 1'b1;
    BRDY <= 1'b1;
    for (k = 0; k < 50; k++) begin
      @(posedge CORE_CLK);
      if (AWV && AWR === 1'b1) AWV <= 1'b0;
      if (WV && WR === 1'b1) WV <= 1'b0;
      if (BV === 1'b1) break;
    end
    rs = BRESP;
    BRDY <= 1'b0;
    if (k == 50) begin
      bad_count++;
      stop_test();
    end
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] rs);
    int k;
    @(posedge CORE_CLK);
    ARADDR <= a;
    ARV <= 1'b1;
    RRDY <= 1'b1;
    for (k = 0; k < 50; k++) begin
      @(posedge CORE_CLK);
      if (ARV && ARR === 1'b1) ARV <= 1'b0;
      if (RV === 1'b1) break;
    end
    v = RDATA;
    rs = RRESP;
    RRDY <= 1'b0;
    if (k == 50) begin
      bad_count++;
      stop_test();
    end
  endtask

  initial begin
    rows = '{'{0, DEC_X1, 0, 1, 0, 32'h2}, '{0, DEC_X2, 0, 0, 0, 32'hFFFF_FFFC},
      '{0, DEC_X4, 0, 1, 0, 32'h8}, '{0, DEC_X4, 1, 1, 0, 32'hFFFF_FFF8},
      '{0, DEC_UPDOWN, 0, 0, 0, 32'hFFFF_FFFE}, '{1, DEC_X4, 0, 1, 0, 32'h8},
      '{1, DEC_X1, 0, 0, 0, 32'hFFFF_FFFE}, '{1, DEC_UPDOWN, 1, 1, 0, 32'hFFFF_FFFE},
      '{1, DEC_X4, 0, 1, 1, 32'h0}, '{0, DEC_X4, 0, 0, 1, 32'hFFFF_FFF8}};
    tick(10);
    SRST <= 1'b0;
    tick(3);
    rd(CTRL_OFF, d, r);
    check(d, CTRL_RESET);
    check(HW_UP, 1'b1);
    $display("reset test done");
    // Each row sets one decoder mode, moves two cycles and checks the count change.
    for (i = 0; i < 10; i++) begin
      c = CTRL_RESET;
      if (rows[i].sel) {c[HW_REV_BIT], c[HW_MODE_LSB +: 2]} = {rows[i].rev, rows[i].mode};
      else {c[ENC_REV_BIT], c[ENC_MODE_LSB +: 2]} = {rows[i].rev, rows[i].mode};
      wr(CTRL_OFF, c, r);
      HANDWHEEL_ENABLE_N <= rows[i].en_n;
      rd(COUNT_BASE_OFF + {rows[i].sel, 2'h0}, b0, r);
      model.move(rows[i].sel, rows[i].up, rows[i].mode == DEC_UPDOWN, 2);
      tick(8);
      rd(COUNT_BASE_OFF + {rows[i].sel, 2'h0}, d, r);
      check(d - b0, rows[i].exp);
    end
    HANDWHEEL_ENABLE_N <= 1'b0;
    $display("decoder table done");
    wr(FEED_LEN_OFF, 32'h0000_1234, r);
    check(JOG_FEED_LENGTH, 32'h0000_1234);
    // Feed-length, constant and high-speed jog modes once; the constant mode uses the minus switch.
    for (i = 0; i < 3; i++) begin
      wr(CTRL_OFF, CTRL_RESET | (i << JOG_MODE_LSB), r);
      s0 = n_start;
      r0 = n_rel;
      if (i == 1) JOG_MINUS_IN <= 1'b0;
      else JOG_PLUS_IN <= 1'b0;
      tick(6);
      check(n_start - s0, 1);
      check(JOG_DIR_PLUS, i != 1);
      check(JOG_FEED_MODE, i);
      JOG_PLUS_IN <= 1'b1;
      JOG_MINUS_IN <= 1'b1;
      tick(6);
      check(n_rel - r0, i != 0);
    end
    HANDWHEEL_ENABLE_N <= 1'b1;
    JOG_PLUS_IN <= 1'b0;
    tick(6);
    check(n_start - s0, 1);
    JOG_PLUS_IN <= 1'b1;
    HANDWHEEL_ENABLE_N <= 1'b0;
    $display("jog test done");
    wr(CTRL_OFF, CTRL_RESET | (1 << USE_MARKER_BIT), r);
    ORIGIN_RETURN_ACTIVE <= 1'b1;
    s0 = n_home;
    model.move(0, 1, 0, 2);
    check(n_home - s0, 1);
    ORIGIN_RETURN_ACTIVE <= 1'b0;
    model.move(0, 1, 0, 2);
    check(n_home - s0, 1);
    $display("marker test done");
    // The sense is flipped only while the pin is idle in the new sense.
    s0 = n_ovr;
    TARGET_OVERRIDE_TRIGGER <= 1'b0;
    SERVO_IN_POSITION <= 1'b0;
    tick(6);
    check(n_ovr - s0, 1);
    check(IN_POSITION, 1'b1);
    wr(CTRL_OFF, CTRL_RESET | (1 << (POL_LSB + POL_OVR)), r);
    TARGET_OVERRIDE_TRIGGER <= 1'b1;
    tick(6);
    check(n_ovr - s0, 2);
    rd(EXT_STATUS_OFF, d, r);
    check(d[7:0], 8'h2F);
    $display("polarity test done");
    wr(CTRL_OFF, CTRL_RESET | (4'h9 << CLEAR_SEL_LSB), r);
    rd(COUNT_BASE_OFF + 8'h04, b0, r);
    COUNTER_CLEAR_IN <= 1'b0;
    tick(3);
    COUNTER_CLEAR_IN <= 1'b1;
    tick(6);
    rd(COUNT_BASE_OFF, d, r);
    check(d, 32'h0);
    rd(COUNT_BASE_OFF + 8'h0C, d, r);
    check(d, 32'h0);
    rd(COUNT_BASE_OFF + 8'h04, d, r);
    check(d, b0);
    $display("clear test done");
    rd(8'h40, d, r);
    check(d, 32'h0);
    check(r, RESP_SLVERR);
    wr(8'h40, 32'hFFFF_FFFF, r);
    check(r, RESP_SLVERR);
    s0 = n_ovr;
    SRST <= 1'b1;
    tick(3);
    SRST <= 1'b0;
    tick(3);
    rd(CTRL_OFF, d, r);
    check(d, CTRL_RESET);
    check(JOG_FEED_LENGTH, FEED_LEN_RESET);
    check(n_ovr - s0, 0);
    $display("bus and second reset test done");
    stop_test();
  end
endmodule
